// [design/cwdu_watchdog.sv]
`include "cwdu_map.svh"

module cwdu_watchdog
#(
    parameter int MS_CYCLES = `CWDU_TICK_US * `CWDU_CLK_MHZ,
    parameter int TIMEOUT_MS = `CWDU_TIMEOUT_MS
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic io_wr_en,
    input wire logic io_rd_en,
    input wire logic [`CWDU_IO_ADDR_W-1:0] io_addr,
    input wire logic io_wr_data,
    input wire logic system_write_instruction_valid,
    input wire logic [15:0] system_write_instruction_code,
    input wire logic [1:0] system_write_instruction_operand,
    input wire logic supply_fault,
    output logic io_module_wr_en,
    output logic [`CWDU_IO_ADDR_W-1:0] io_module_addr,
    output logic io_module_wr_data,
    output logic io_rd_hit,
    output logic io_rd_data,
    output logic wd_toggle_out,
    output logic relay_on,
    output logic sw_active,
    output logic fault_handler_call,
    output logic cold_start,
    output logic hist_valid,
    output cwdu_pkg::cwdu_hist_t hist_code
);
    import cwdu_pkg::*;

    localparam int DW = $clog2(MS_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // Millisecond time base
    logic [DW-1:0] div_cnt;
    logic [DW-1:0] next_div_cnt;
    logic ms_tick;
    logic next_ms_tick;

    always_comb
    begin
        next_ms_tick = (div_cnt == DW'(MS_CYCLES - 1));
        next_div_cnt = next_ms_tick ? '0 : div_cnt + DW'(1);
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_cnt <= '0;
            ms_tick <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            ms_tick <= next_ms_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I/O access: toggle output, status input, pass-through to modules
    function automatic logic addr_is(input logic [`CWDU_IO_ADDR_W-1:0] a,
                                     input logic [`CWDU_IO_ADDR_W-1:0] b);
        addr_is = (a == b);
    endfunction : addr_is

    logic hw_expired;
    logic toggle_change;
    logic next_toggle;
    logic next_relay;
    logic next_mod_wr;
    logic next_rd_hit;
    logic next_rd_data;

    always_comb
    begin
        toggle_change = io_wr_en && addr_is(io_addr, `CWDU_ADDR_TOGGLE)
            && (io_wr_data != wd_toggle_out);
        next_toggle = toggle_change ? io_wr_data : wd_toggle_out;
        next_relay = relay_on;
        if (toggle_change)
        begin
            next_relay = 1'b1;
        end
        else if (hw_expired)
        begin
            next_relay = 1'b0;
        end
        next_mod_wr = io_wr_en && !addr_is(io_addr, `CWDU_ADDR_TOGGLE);
        next_rd_hit = io_rd_en && addr_is(io_addr, `CWDU_ADDR_STATUS);
        next_rd_data = next_rd_hit && relay_on;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wd_toggle_out <= 1'b0;
            relay_on <= 1'b0;
            io_module_wr_en <= 1'b0;
            io_module_addr <= '0;
            io_module_wr_data <= 1'b0;
            io_rd_hit <= 1'b0;
            io_rd_data <= 1'b0;
        end
        else
        begin
            wd_toggle_out <= next_toggle;
            relay_on <= next_relay;
            io_module_wr_en <= next_mod_wr;
            io_module_addr <= io_addr;
            io_module_wr_data <= io_wr_data;
            io_rd_hit <= next_rd_hit;
            io_rd_data <= next_rd_data;
        end
    end

    cwdu_interval_timer #(.LIMIT(TIMEOUT_MS)) u_hw_timer
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(ms_tick),
        .run(relay_on),
        .restart(toggle_change),
        .expired(hw_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Software watchdog
    cwdu_sw_state_t sw_state;
    cwdu_sw_state_t next_sw_state;
    logic [1:0] sw_mode;
    logic [1:0] next_sw_mode;
    logic sw_expired;
    logic wd_cmd;
    logic retrigger;
    logic next_call;
    logic next_cold;

    always_comb
    begin
        wd_cmd = system_write_instruction_valid && (system_write_instruction_code == `CWDU_SYSTEM_WRITE_INSTRUCTION_WDOG);
        retrigger = 1'b0;
        next_sw_state = sw_state;
        next_sw_mode = sw_mode;
        next_call = 1'b0;
        next_cold = 1'b0;
        case (sw_state)
            CWDU_SW_OFF, CWDU_SW_ARMED:
            begin
                if (sw_state == CWDU_SW_ARMED && sw_expired)
                begin
                    if (sw_mode == `CWDU_OP_HANDLER)
                    begin
                        next_sw_state = CWDU_SW_HANDLER;
                        next_call = 1'b1;
                    end
                    else
                    begin
                        next_sw_state = CWDU_SW_COLD;
                        next_cold = 1'b1;
                    end
                end
                else if (wd_cmd && system_write_instruction_operand == `CWDU_OP_OFF)
                begin
                    next_sw_state = CWDU_SW_OFF;
                end
                else if (wd_cmd && (system_write_instruction_operand == `CWDU_OP_COLD
                    || system_write_instruction_operand == `CWDU_OP_HANDLER))
                begin
                    next_sw_state = CWDU_SW_ARMED;
                    next_sw_mode = system_write_instruction_operand;
                    retrigger = 1'b1;
                end
            end
            CWDU_SW_HANDLER:
            begin
                next_sw_state = CWDU_SW_COLD;
                next_cold = 1'b1;
            end
            CWDU_SW_COLD:
            begin
                next_sw_state = CWDU_SW_OFF;
            end
            default:
            begin
                next_sw_state = CWDU_SW_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sw_state <= CWDU_SW_OFF;
            sw_mode <= `CWDU_OP_OFF;
            sw_active <= 1'b0;
            cold_start <= 1'b0;
        end
        else
        begin
            sw_state <= next_sw_state;
            sw_mode <= next_sw_mode;
            sw_active <= (next_sw_state == CWDU_SW_ARMED);
            cold_start <= next_cold;
        end
    end

    cwdu_interval_timer #(.LIMIT(TIMEOUT_MS)) u_sw_timer
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(ms_tick),
        .run(sw_state == CWDU_SW_ARMED),
        .restart(retrigger),
        .expired(sw_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Supply fault input and history log
    logic [2:0] sf_sync;
    logic sf_level;
    logic sf_pend;
    logic next_sf_level;
    logic next_sf_pend;
    logic next_hist_valid;
    cwdu_hist_t next_hist_code;

    always_comb
    begin
        next_sf_level = (sf_sync[1] == sf_sync[2]) ? sf_sync[2] : sf_level;
        next_sf_pend = sf_pend || (next_sf_level && !sf_level);
        next_hist_valid = 1'b0;
        next_hist_code = CWDU_HIST_NONE;
        if (next_call)
        begin
            next_hist_valid = 1'b1;
            next_hist_code = CWDU_HIST_WDOG;
        end
        else if (sf_pend)
        begin
            next_hist_valid = 1'b1;
            next_hist_code = CWDU_HIST_SUPPLY;
            next_sf_pend = next_sf_level && !sf_level;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sf_sync <= 3'h0;
            sf_level <= 1'b0;
            sf_pend <= 1'b0;
            hist_valid <= 1'b0;
            hist_code <= CWDU_HIST_NONE;
            fault_handler_call <= 1'b0;
        end
        else
        begin
            sf_sync <= {sf_sync[1:0], supply_fault};
            sf_level <= next_sf_level;
            sf_pend <= next_sf_pend;
            hist_valid <= next_hist_valid;
            hist_code <= next_hist_code;
            fault_handler_call <= next_hist_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence handler_then_cold;
        fault_handler_call && hist_code == CWDU_HIST_WDOG ##1 cold_start;
    endsequence

    relay_energise_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        toggle_change |=> relay_on && wd_toggle_out == $past(io_wr_data))
        else $error("relay not energised after toggle");
    relay_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        hw_expired && !toggle_change |=> !relay_on)
        else $error("relay held after missed toggle");
    status_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        io_rd_en && io_addr == `CWDU_ADDR_STATUS
        |=> io_rd_hit && io_rd_data == $past(relay_on))
        else $error("status read wrong");
    toggle_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        io_wr_en && io_addr == `CWDU_ADDR_TOGGLE |=> !io_module_wr_en)
        else $error("toggle write reached modules");
    sw_arm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sw_state == CWDU_SW_OFF && wd_cmd && system_write_instruction_operand == `CWDU_OP_COLD
        |=> sw_active ##1 !cold_start)
        else $error("software watchdog not armed");
    cold_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sw_state == CWDU_SW_ARMED && sw_expired && sw_mode == `CWDU_OP_COLD
        |=> cold_start && hist_code != CWDU_HIST_WDOG)
        else $error("missing cold start");
    handler_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sw_state == CWDU_SW_ARMED && sw_expired
        && sw_mode == `CWDU_OP_HANDLER |=> handler_then_cold)
        else $error("handler call or cold start out of order");
    history_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        next_call |=> fault_handler_call && hist_code == CWDU_HIST_WDOG)
        else $error("handler call not logged");
    sw_disarm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wd_cmd && system_write_instruction_operand == `CWDU_OP_OFF && !sw_expired
        && (sw_state == CWDU_SW_ARMED || sw_state == CWDU_SW_OFF)
        |=> !sw_active ##1 !cold_start)
        else $error("software watchdog not disarmed");

endmodule : cwdu_watchdog

// [design/cwdu_map.svh]
// Notes on behaviour
// - The relay stays energised only while the toggle output changes within every 200 ms.
// - If the toggle output does not change within the supervision interval, the relay drops out.
// - The relay state reads back on status input 0x1fab, with 1 meaning the relay is energised.
// - Toggle output address 0xff is never passed on to digital I/O modules.
// - The software watchdog arms on the first watchdog system write with operand 1 or 2 and needs a retrigger every 200 ms.
// - With operand 1 a missed retrigger within 200 ms gives a cold start.
// - With operand 2 a missed retrigger first calls fault handler block zero, then a cold start.
// - Each fault handler call is logged, marking watchdog cause apart from supply fault cause.
`ifndef CWDU_MAP_SVH
`define CWDU_MAP_SVH

`define CWDU_IO_ADDR_W 13
`define CWDU_ADDR_TOGGLE 13'h00ff
`define CWDU_ADDR_STATUS 13'h1fab
`define CWDU_SYSTEM_WRITE_INSTRUCTION_WDOG 16'h03e8
`define CWDU_OP_OFF 2'h0
`define CWDU_OP_COLD 2'h1
`define CWDU_OP_HANDLER 2'h2
`define CWDU_CLK_MHZ 100
`define CWDU_TICK_US 1000
`define CWDU_TIMEOUT_MS 200

`endif

// [design/cwdu_pkg.sv]
package cwdu_pkg;

    typedef enum logic [3:0]
    {
        CWDU_SW_OFF = 4'b0001,
        CWDU_SW_ARMED = 4'b0010,
        CWDU_SW_HANDLER = 4'b0100,
        CWDU_SW_COLD = 4'b1000
    } cwdu_sw_state_t;

    typedef enum logic [1:0]
    {
        CWDU_HIST_NONE = 2'h0,
        CWDU_HIST_SUPPLY = 2'h1,
        CWDU_HIST_WDOG = 2'h2
    } cwdu_hist_t;

endpackage : cwdu_pkg

// [design/cwdu_interval_timer.sv]
module cwdu_interval_timer
#(
    parameter int LIMIT = 200
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    output logic expired
);
    localparam int CW = $clog2(LIMIT + 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_expired;

    // Counts time base ticks since the last restart; one pulse at the limit
    always_comb
    begin
        next_count = count;
        next_expired = 1'b0;
        if (!run || restart)
        begin
            next_count = '0;
        end
        else if (tick)
        begin
            if (count == CW'(LIMIT - 1))
            begin
                next_count = '0;
                next_expired = 1'b1;
            end
            else
            begin
                next_count = count + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= '0;
            expired <= 1'b0;
        end
        else
        begin
            count <= next_count;
            expired <= next_expired;
        end
    end

endmodule : cwdu_interval_timer

// [testbench/cwdu_prog_model.sv]
`include "cwdu_map.svh"

module cwdu_prog_model
(
    input wire logic ref_clk,
    input wire logic io_rd_hit,
    input wire logic io_rd_data,
    output logic io_wr_en,
    output logic io_rd_en,
    output logic [`CWDU_IO_ADDR_W-1:0] io_addr,
    output logic io_wr_data,
    output logic system_write_instruction_valid,
    output logic [15:0] system_write_instruction_code,
    output logic [1:0] system_write_instruction_operand,
    output logic supply_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog;

    initial
    begin
        tog = 1'b0;
        {io_wr_en, io_rd_en, io_wr_data, system_write_instruction_valid, supply_fault} = '0;
        io_addr = '0;
        system_write_instruction_code = '0;
        system_write_instruction_operand = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released lines show the inverse of their last value
    task automatic io_write(input logic [12:0] a, input logic d);
        @(posedge ref_clk);
        io_wr_en <= 1'b1;
        io_addr <= a;
        io_wr_data <= d;
        @(posedge ref_clk);
        io_wr_en <= 1'b0;
        io_addr <= ~a;
        io_wr_data <= ~d;
    endtask : io_write

    task automatic io_read(input logic [12:0] a, output logic h,
                           output logic d);
        @(posedge ref_clk);
        io_rd_en <= 1'b1;
        io_addr <= a;
        @(posedge ref_clk);
        io_rd_en <= 1'b0;
        io_addr <= ~a;
        #1;
        h = io_rd_hit;
        d = io_rd_data;
    endtask : io_read

    task automatic sys_write(input logic [1:0] op);
        @(posedge ref_clk);
        system_write_instruction_valid <= 1'b1;
        system_write_instruction_code <= `CWDU_SYSTEM_WRITE_INSTRUCTION_WDOG;
        system_write_instruction_operand <= op;
        @(posedge ref_clk);
        system_write_instruction_valid <= 1'b0;
        system_write_instruction_code <= ~`CWDU_SYSTEM_WRITE_INSTRUCTION_WDOG;
        system_write_instruction_operand <= ~op;
    endtask : sys_write

    // Long program cycles repeat the toggle several times
    task automatic toggle(input int n, input int gap);
        repeat (n)
        begin
            tog = ~tog;
            io_write(`CWDU_ADDR_TOGGLE, tog);
            repeat (gap) @(posedge ref_clk);
        end
    endtask : toggle

    task automatic set_supply(input logic v);
        @(posedge ref_clk);
        supply_fault <= v;
    endtask : set_supply
endmodule : cwdu_prog_model

// [testbench/cwdu_watchdog_tb.sv]
`include "cwdu_map.svh"

module cwdu_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cwdu_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic io_wr_en, io_rd_en, io_wr_data, system_write_instruction_valid, supply_fault;
    logic [`CWDU_IO_ADDR_W-1:0] io_addr, io_module_addr;
    logic [15:0] system_write_instruction_code;
    logic [1:0] system_write_instruction_operand;
    logic io_module_wr_en, io_module_wr_data, io_rd_hit, io_rd_data;
    logic wd_toggle_out, relay_on, sw_active, fault_handler_call;
    logic cold_start, hist_valid, h, d;
    cwdu_hist_t hist_code, last_hist;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0, n_cold = 0, n_hand = 0, n_mod = 0, n_drop = 0;
    int t_cold = 0, t_hand = 0, c;

    always #5 ref_clk = ~ref_clk;

    cwdu_watchdog #(.MS_CYCLES(10), .TIMEOUT_MS(5)) dut
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .io_wr_en(io_wr_en),
        .io_rd_en(io_rd_en), .io_addr(io_addr), .io_wr_data(io_wr_data),
        .system_write_instruction_valid(system_write_instruction_valid), .system_write_instruction_code(system_write_instruction_code),
        .system_write_instruction_operand(system_write_instruction_operand), .supply_fault(supply_fault),
        .io_module_wr_en(io_module_wr_en), .io_module_addr(io_module_addr),
        .io_module_wr_data(io_module_wr_data), .io_rd_hit(io_rd_hit),
        .io_rd_data(io_rd_data), .wd_toggle_out(wd_toggle_out),
        .relay_on(relay_on), .sw_active(sw_active),
        .fault_handler_call(fault_handler_call), .cold_start(cold_start),
        .hist_valid(hist_valid), .hist_code(hist_code)
    );

    cwdu_prog_model prog
    (
        .ref_clk(ref_clk), .io_rd_hit(io_rd_hit), .io_rd_data(io_rd_data),
        .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_addr(io_addr),
        .io_wr_data(io_wr_data), .system_write_instruction_valid(system_write_instruction_valid),
        .system_write_instruction_code(system_write_instruction_code), .system_write_instruction_operand(system_write_instruction_operand),
        .supply_fault(supply_fault)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pulse and event bookkeeping, in cycles
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cold_start === 1'b1)
        begin
            n_cold <= n_cold + 1;
            t_cold <= cyc;
        end
        if (fault_handler_call === 1'b1)
        begin
            n_hand <= n_hand + 1;
            t_hand <= cyc;
        end
        if (hist_valid === 1'b1)
            last_hist <= hist_code;
        n_mod <= n_mod + int'(io_module_wr_en === 1'b1);
        n_drop <= n_drop + int'(rst_b && $fell(relay_on));
    end

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic wait_cold(input int lim);
        int k;
        for (k = 0; k < lim && cold_start !== 1'b1; k++)
            step(1);
        if (cold_start !== 1'b1)
        begin
            fail_count++;
            summarize();
        end
    endtask : wait_cold

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        step(1);
        check("relay_reset", relay_on, 1'b0);
        check("sw_reset", sw_active, 1'b0);
        prog.io_read(`CWDU_ADDR_STATUS, h, d);
        check("rd_hit", h, 1'b1);
        check("rd_off", d, 1'b0);
        prog.toggle(1, 0);
        step(0);
        check("relay_on", relay_on, 1'b1);
        check("toggle_bit", wd_toggle_out, prog.tog);
        prog.io_read(`CWDU_ADDR_STATUS, h, d);
        check("rd_on", d, 1'b1);
        prog.toggle(6, 30);
        check("no_drop", n_drop, 0);
        check("no_fwd", n_mod, 0);
        prog.io_write(`CWDU_ADDR_TOGGLE, prog.tog);
        step(8);
        check("relay_40", relay_on, 1'b1);
        step(30);
        check("relay_70", relay_on, 1'b0);
        prog.io_read(`CWDU_ADDR_STATUS, h, d);
        check("rd_drop", d, 1'b0);
        prog.io_write(13'h00f0, 1'b1);
        step(0);
        check("mod_wr", io_module_wr_en, 1'b1);
        check("mod_addr", io_module_addr, 13'h00f0);
        check("mod_data", io_module_wr_data, 1'b1);
        step(1);
        check("fwd_other", n_mod, 1);
        prog.io_read(13'h00f0, h, d);
        check("rd_refused", h, 1'b0);
        prog.sys_write(`CWDU_OP_COLD);
        step(0);
        check("sw_arm", sw_active, 1'b1);
        repeat (4)
        begin
            step(30);
            prog.sys_write(`CWDU_OP_COLD);
        end
        check("no_cold", n_cold, 0);
        wait_cold(80);
        step(1);
        check("cold_no_hand", n_hand, 0);
        check("sw_off_cold", sw_active, 1'b0);
        prog.sys_write(`CWDU_OP_HANDLER);
        wait_cold(80);
        step(1);
        check("hand_once", n_hand, 1);
        check("hand_order", t_cold - t_hand, 1);
        check("hist_wdog", last_hist, CWDU_HIST_WDOG);
        c = n_cold;
        prog.sys_write(`CWDU_OP_HANDLER);
        step(10);
        prog.sys_write(`CWDU_OP_OFF);
        step(0);
        check("sw_disarm", sw_active, 1'b0);
        step(100);
        check("no_action", n_cold, c);
        prog.sys_write(2'h3);
        step(0);
        check("op3_ignored", sw_active, 1'b0);
        prog.set_supply(1'b1);
        step(12);
        check("hist_supply", last_hist, CWDU_HIST_SUPPLY);
        check("hand_supply", n_hand, 2);
        prog.set_supply(1'b0);
        step(5);
        summarize();
    end
endmodule : cwdu_watchdog_tb
